//--- logic/dpfc_host.sv
// Host controller that drives a dual-plane parallel flash through its pins.
// Function
// R01 - Device starts in read mode; only written sequences change its mode.
// R02 - Device has two planes; plane chosen by the top address bits.
// R03 - Reads to the idle plane may proceed during a program or erase.
// R04 - Erase suspend holds an erase; other sectors then readable or programmable.
// R05 - Completion seen by ready pin, polling bit and toggle bit.
// R06 - After the six-cycle bypass unlock each single write programs one location.
// R07 - Bypass mode lasts until power off or a reset pulse.
// R08 - In bypass mode erase and suspend cycles program data; host refuses them.
// R09 - Width pin high selects word mode with sixteen data lines.
// R10 - Width pin low: byte mode, line 15 becomes the low byte address.
// R11 - Read: chip select and output enable low, write strobe high.
// R12 - Device data lines float whenever chip select or output enable is high.
// R13 - Write: strobe low with chip select low and output enable high.
// R14 - Command decoding ignores data lines 8 to 15.
// R15 - Reset low aborts the operation; afterwards the device is in read mode.
// R16 - High-voltage reset level lets locked sectors be altered.
// R17 - Erase sets bits to one; program only clears bits.
// R18 - Chip erase is six cycles, self-timed, then back to read mode.
// R19 - Chip erase skips locked sectors.
// R20 - Sector erase: sixth cycle carries sector address and code 30.
// R21 - Erasing a locked sector changes nothing and ends within 2 us.
// R22 - Program is four cycles; commands during programming are ignored.
// R23 - Polling: bit 7 complemented during program, zero during erase.
// R24 - Toggle bit 6 alternates on successive reads during an operation.
// R25 - Erase sequences begin with the five unlock writes.
// R26 - A mismatched cycle discards the partial sequence.
`timescale 1ns/1ns
module dpfc_host
  import dpfc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              cmd_valid,
  output logic                   cmd_ready,
  input  wire dpfc_op_t          cmd_op,
  input  wire logic [ADDR_W-1:0] cmd_addr,
  input  wire logic [DATA_W-1:0] cmd_data,
  input  wire logic              word_mode,
  output logic                   rsp_valid,
  output logic [DATA_W-1:0]      rsp_data,
  output logic                   rsp_error,
  output logic                   bypass_active,
  output logic                   erase_suspended,
  output logic [ADDR_W-1:0]      flash_addr,
  output logic [DATA_W-1:0]      flash_dq_out,
  output logic [DATA_W-1:0]      flash_dq_oe,
  input  wire logic [DATA_W-1:0] flash_dq_in,
  output logic                   flash_ce_n,
  output logic                   flash_oe_n,
  output logic                   flash_we_n,
  output logic                   flash_reset_n,
  output logic                   flash_byte,
  input  wire logic              flash_ready
);

  typedef enum logic [2:0] {
    DPFC_IDLE, DPFC_SEQ, DPFC_POLL, DPFC_POLL_CHECK, DPFC_RESET_PULSE, DPFC_RESP
  } dpfc_state_t;

  dpfc_state_t       state;
  dpfc_op_t          op;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] data;
  logic [2:0]        step;
  logic [8:0]        rcnt;
  logic              first_poll;
  logic              last_toggle;
  logic              bc_start;
  logic              bc_write;
  logic              bc_done;
  logic              bc_oe;
  logic [DATA_W-1:0] bc_rdata;
  logic [ADDR_W-1:0] bc_addr;
  logic [DATA_W-1:0] bc_wdata;

  // Unlock prefix address and data for a command cycle; low byte only carries the code. [R14]
  function automatic logic [ADDR_W+7:0] seq_cycle(input dpfc_op_t o, input logic [2:0] s,
                                                  input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] ua;
    logic [7:0]        ud;
    ua = (s == 3'd1 || s == 3'd4) ? UNLOCK_ADDR_2 : UNLOCK_ADDR_1;
    ud = (s == 3'd1 || s == 3'd4) ? CODE_UNLOCK_2 : (s == 3'd2) ? CODE_ERASE : CODE_UNLOCK_1;
    unique case (o)
      DPFC_OP_PROGRAM:      if (s == 3'd2) ud = CODE_PROGRAM;
      DPFC_OP_BYPASS:       if (s == 3'd5) ud = CODE_BYPASS;   // Same prefix as the erases.
      DPFC_OP_SECTOR_ERASE: if (s == 3'd5) begin ua = a; ud = CODE_SECTOR; end
      DPFC_OP_CHIP_ERASE:   if (s == 3'd5) ud = CODE_CHIP;
      DPFC_OP_SUSPEND:      begin ua = a; ud = CODE_SUSPEND; end
      DPFC_OP_RESUME:       begin ua = a; ud = CODE_RESUME; end
      default:              ua = a;
    endcase
    return {ua, ud};
  endfunction : seq_cycle

  // Cycles per command: erases and bypass unlock take six, program four, or one in bypass mode. [R18] [R20] [R22] [R25]
  function automatic logic [2:0] seq_len(input dpfc_op_t o, input logic byp);
    unique case (o)
      DPFC_OP_PROGRAM:      seq_len = byp ? 3'd0 : 3'd3;   // Bypass: single pulse only. [R06]
      DPFC_OP_CHIP_ERASE,
      DPFC_OP_SECTOR_ERASE,
      DPFC_OP_BYPASS:       seq_len = 3'd5;
      default:              seq_len = 3'd0;
    endcase
  endfunction : seq_len

  wire [ADDR_W+7:0] cyc       = seq_cycle(op, step, addr);
  wire              is_data   = (op == DPFC_OP_PROGRAM) && (step == seq_len(op, bypass_active));
  wire              is_read   = (op == DPFC_OP_READ);
  wire              waits     = (op == DPFC_OP_PROGRAM) || (op == DPFC_OP_CHIP_ERASE)
                                || (op == DPFC_OP_SECTOR_ERASE);
  // In bypass mode an erase or suspend write would program data, so refuse it. [R08]
  wire              refused   = bypass_active && (cmd_op == DPFC_OP_CHIP_ERASE
                                || cmd_op == DPFC_OP_SECTOR_ERASE || cmd_op == DPFC_OP_SUSPEND
                                || cmd_op == DPFC_OP_RESUME || cmd_op == DPFC_OP_BYPASS);
  wire              poll_done = !first_poll && (bc_rdata[TOGGLE_BIT] == last_toggle)
                                && flash_ready;                                     // [R05] [R24]
  wire              poll_fail = (op == DPFC_OP_PROGRAM)
                                && (bc_rdata[POLL_BIT] != data[POLL_BIT]);          // [R23]

  assign cmd_ready = (state == DPFC_IDLE);
  assign bc_addr   = is_read || is_data || state == DPFC_POLL ? addr : cyc[ADDR_W+7:8];
  // Reads carry the byte select in bit 15, so byte-mode reads reach either half of a word.
  assign bc_wdata  = (is_data || is_read) ? data : {8'h00, cyc[7:0]};
  // Byte mode: line 15 is the low byte address for every cycle, reads and polls too,
  // because a floating select would let the device pick a byte on its own. [R09] [R10]
  wire byte_sel_drive = !word_mode && !flash_ce_n;
  assign flash_dq_oe = bc_oe          ? (word_mode ? 16'hFFFF : 16'h80FF) :
                       byte_sel_drive ? 16'h8000 : 16'h0000;
  assign flash_byte  = word_mode;

  dpfc_bus_cycle u_bus (
    .clk      (clk),
    .rst      (rst),
    .start    (bc_start),
    .write    (bc_write),
    .addr     (bc_addr),
    .wdata    (bc_wdata),
    .dq_in    (flash_dq_in),
    .busy     (),
    .done     (bc_done),
    .rdata    (bc_rdata),
    .pin_addr (flash_addr),
    .dq_out   (flash_dq_out),
    .dq_oe    (bc_oe),
    .ce_n     (flash_ce_n),
    .oe_n     (flash_oe_n),
    .we_n     (flash_we_n)
  );

  // Sequencer: issues the command cycles, then polls the device until a program or erase finishes.
  always_ff @(posedge clk) begin
    bc_start  <= 1'b0;
    rsp_valid <= 1'b0;
    if (rst) begin
      state           <= DPFC_IDLE;                  // Device begins in read mode. [R01]
      op              <= DPFC_OP_READ;
      addr            <= 20'h0_0000;
      data            <= 16'h0000;
      step            <= 3'h0;
      rcnt            <= 9'h000;
      first_poll      <= 1'b1;
      last_toggle     <= 1'b0;
      bc_write        <= 1'b0;
      rsp_data        <= 16'h0000;
      rsp_error       <= 1'b0;
      bypass_active   <= 1'b0;
      erase_suspended <= 1'b0;
      flash_reset_n   <= 1'b0;
    end else begin
      flash_reset_n <= 1'b1;
      unique case (state)
        DPFC_IDLE: if (cmd_valid) begin
          op    <= cmd_op;
          addr  <= cmd_addr;
          data  <= cmd_data;
          step  <= 3'h0;
          if (refused) begin
            rsp_error <= 1'b1;
            state     <= DPFC_RESP;
          end else if (cmd_op == DPFC_OP_RESET) begin
            flash_reset_n <= 1'b0;                   // Abort and leave bypass mode. [R07] [R15]
            rsp_error     <= 1'b0;
            rcnt          <= 9'(RESET_PULSE_CYC);
            state         <= DPFC_RESET_PULSE;
          end else begin
            rsp_error <= 1'b0;
            bc_write  <= (cmd_op != DPFC_OP_READ);
            bc_start  <= 1'b1;
            state     <= DPFC_SEQ;
          end
        end
        DPFC_SEQ: if (bc_done) begin
          if (step != seq_len(op, bypass_active)) begin
            step     <= step + 3'h1;                 // Next cycle of the sequence. [R13]
            bc_start <= 1'b1;
          end else if (is_read) begin
            rsp_data <= bc_rdata;
            state    <= DPFC_RESP;
          end else begin
            if (op == DPFC_OP_BYPASS) bypass_active <= 1'b1;            // [R06]
            if (op == DPFC_OP_SUSPEND) erase_suspended <= 1'b1;         // [R04]
            if (op == DPFC_OP_RESUME) erase_suspended <= 1'b0;
            first_poll <= 1'b1;
            bc_write   <= 1'b0;
            bc_start   <= waits;
            state      <= waits ? DPFC_POLL : DPFC_RESP;
          end
        end
        DPFC_POLL: if (bc_done) state <= DPFC_POLL_CHECK;
        DPFC_POLL_CHECK: begin
          first_poll  <= 1'b0;
          last_toggle <= bc_rdata[TOGGLE_BIT];
          if (poll_done) begin
            rsp_data  <= bc_rdata;
            rsp_error <= poll_fail;
            state     <= DPFC_RESP;
          end else begin
            bc_start <= 1'b1;                        // Toggle reads go to the busy plane. [R03]
            state    <= DPFC_POLL;
          end
        end
        DPFC_RESET_PULSE: begin
          flash_reset_n <= (rcnt == 9'h001);
          rcnt          <= rcnt - 9'h001;
          if (rcnt == 9'h001) begin
            bypass_active   <= 1'b0;
            erase_suspended <= 1'b0;
            state           <= DPFC_RESP;
          end
        end
        DPFC_RESP: begin
          rsp_valid <= 1'b1;
          state     <= DPFC_IDLE;
        end
      endcase
    end
  end

  // A refused command never reaches the pins and always answers with an error.
  refuse_no_cycle_a: assert property (@(posedge clk) disable iff (rst)
    (cmd_valid && cmd_ready && refused) |=> (state == DPFC_RESP) ##1 (rsp_valid && rsp_error))
    else $error("bypass refusal not answered"); // [R08]
  reset_pulse_a: assert property (@(posedge clk) disable iff (rst)
    $fell(flash_reset_n) |-> !flash_reset_n [*8]) else $error("reset pulse too short"); // [R15]
  bypass_clear_a: assert property (@(posedge clk) disable iff (rst)
    $rose(flash_reset_n) |=> !bypass_active) else $error("bypass survives reset"); // [R07]
  byte_lanes_a: assert property (@(posedge clk) disable iff (rst)
    !word_mode |-> flash_dq_oe[14:8] == 7'h00) else $error("upper lines driven"); // [R10]
  poll_ready_a: assert property (@(posedge clk) disable iff (rst)
    (state == DPFC_POLL_CHECK && !flash_ready) |=> state == DPFC_POLL)
    else $error("finished while busy"); // [R05]

endmodule : dpfc_host

//--- logic/dpfc_pkg.sv
// Package of pin constants, command codes and timing counts for the flash host controller.
package dpfc_pkg;

  // Clock period in nanoseconds.
  localparam int CLK_PERIOD_NS = 10;

  // Widths of the device pins.
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;

  // Unlock and command addresses and data codes.
  localparam logic [19:0] UNLOCK_ADDR_1 = 20'h0_5555;
  localparam logic [19:0] UNLOCK_ADDR_2 = 20'h0_2AAA;
  localparam logic [7:0]  CODE_UNLOCK_1 = 8'hAA;
  localparam logic [7:0]  CODE_UNLOCK_2 = 8'h55;
  localparam logic [7:0]  CODE_ERASE    = 8'h80;
  localparam logic [7:0]  CODE_CHIP     = 8'h10;
  localparam logic [7:0]  CODE_SECTOR   = 8'h30;
  localparam logic [7:0]  CODE_PROGRAM  = 8'hA0;
  localparam logic [7:0]  CODE_SUSPEND  = 8'hB0;
  localparam logic [7:0]  CODE_RESUME   = 8'h30;
  localparam logic [7:0]  CODE_BYPASS   = 8'h20;

  // Status bit positions in the read data.
  localparam int POLL_BIT   = 7;
  localparam int TOGGLE_BIT = 6;

  // Plane select address bits and the sector count.
  localparam int PLANE_LSB    = 18;
  localparam int SECTOR_COUNT = 40;

  // Bus cycle phase lengths in clocks; each phase is at least one cycle.
  localparam int SETUP_NS   = 20;
  localparam int PULSE_NS   = 40;
  localparam int HOLD_NS    = 20;
  localparam int ACCESS_NS  = 70;
  localparam int SETUP_CYC  = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_CYC  = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC   = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Reset pulse length on the device reset pin.
  localparam int RESET_PULSE_NS  = 500;
  localparam int RESET_PULSE_CYC = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Host commands.
  typedef enum logic [2:0] {
    DPFC_OP_READ,
    DPFC_OP_PROGRAM,
    DPFC_OP_CHIP_ERASE,
    DPFC_OP_SECTOR_ERASE,
    DPFC_OP_SUSPEND,
    DPFC_OP_RESUME,
    DPFC_OP_BYPASS,
    DPFC_OP_RESET
  } dpfc_op_t;

endpackage : dpfc_pkg

//--- logic/dpfc_bus_cycle.sv
// One asynchronous bus cycle (read or write) on the flash pins, timed in clocks.
`timescale 1ns/1ns
module dpfc_bus_cycle
  import dpfc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              start,
  input  wire logic              write,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [DATA_W-1:0] dq_in,
  output logic                   busy,
  output logic                   done,
  output logic [DATA_W-1:0]      rdata,
  output logic [ADDR_W-1:0]      pin_addr,
  output logic [DATA_W-1:0]      dq_out,
  output logic                   dq_oe,
  output logic                   ce_n,
  output logic                   oe_n,
  output logic                   we_n
);

  typedef enum logic [1:0] {DPFC_BC_IDLE, DPFC_BC_SETUP, DPFC_BC_PULSE, DPFC_BC_HOLD} dpfc_bc_t;

  dpfc_bc_t   state;
  logic [3:0] cnt;
  logic       is_write;

  // Phase lengths: reads stretch the strobe to cover the access time.
  wire [3:0] pulse_len = is_write ? 4'(PULSE_CYC) : 4'(ACCESS_CYC);
  wire       last     = (cnt == 4'h1);

  assign busy = (state != DPFC_BC_IDLE);

  // Write: address and chip select settle, then WE pulses low while OE stays high. [R13]
  always_ff @(posedge clk) begin
    done <= 1'b0;
    if (rst) begin
      state    <= DPFC_BC_IDLE;
      cnt      <= 4'h0;
      is_write <= 1'b0;
      rdata    <= 16'h0000;
      pin_addr <= 20'h0_0000;
      dq_out   <= 16'h0000;
      dq_oe    <= 1'b0;
      ce_n     <= 1'b1;
      oe_n     <= 1'b1;
      we_n     <= 1'b1;
    end else begin
      cnt <= last ? 4'h0 : cnt - 4'h1;
      unique case (state)
        DPFC_BC_IDLE: if (start) begin
          state    <= DPFC_BC_SETUP;
          cnt      <= 4'(SETUP_CYC);
          is_write <= write;
          pin_addr <= addr;
          dq_out   <= wdata;
          dq_oe    <= write;
          ce_n     <= 1'b0;
        end
        DPFC_BC_SETUP: if (last) begin
          state <= DPFC_BC_PULSE;
          cnt   <= pulse_len;
          we_n  <= ~is_write;
          oe_n  <= is_write;                        // Read strobe only when not writing. [R11]
        end
        DPFC_BC_PULSE: if (last) begin
          state <= DPFC_BC_HOLD;
          cnt   <= 4'(HOLD_CYC);
          we_n  <= 1'b1;                            // Device latches data on this rise. [R13]
          oe_n  <= 1'b1;
          if (!is_write) rdata <= dq_in;
        end
        DPFC_BC_HOLD: if (last) begin
          state <= DPFC_BC_IDLE;
          ce_n  <= 1'b1;
          dq_oe <= 1'b0;
          done  <= 1'b1;
        end
      endcase
    end
  end

  // Never drive the data lines while the device may be driving them.
  no_contention_a: assert property (@(posedge clk) disable iff (rst)
    !(dq_oe && !oe_n)) else $error("data driven while output enable low"); // [R13]
  write_strobe_a: assert property (@(posedge clk) disable iff (rst)
    !we_n |-> (!ce_n && oe_n)) else $error("write pulse without chip select"); // [R13]

endmodule : dpfc_bus_cycle

//--- verif/dpfc_flash_model.sv
// Behavioural model of the dual-plane flash device seen by the host controller.
`timescale 1ns/1ns
module dpfc_flash_model
  import dpfc_pkg::*;
#(
  parameter int         PROG_NS  = 1000,
  parameter int         ERASE_NS = 4000,
  parameter int         LOCK_NS  = 1500,
  parameter logic [4:0] LOCK_BLK = 5'h1F,
  parameter bit         HV_OVERRIDE = 1'b0
)(
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] dq_in,
  input  wire logic              ce_n,
  input  wire logic              oe_n,
  input  wire logic              we_n,
  input  wire logic              reset_n,
  input  wire logic              word,
  output logic [DATA_W-1:0]      dq_out,
  output logic [DATA_W-1:0]      dq_en,
  output logic                   ready
);
  // Sectors are modelled as 32K-word blocks; the small boot sectors are not split.
  logic [15:0] mem [int];
  logic [19:0] la, op_a;
  logic [15:0] op_d, w;
  logic [2:0]  step = 3'h0;
  logic        bypass = 1'b0, busy = 1'b0, susp = 1'b0, tog = 1'b0, b7;
  int          kind, remain;
  event        go;

  function automatic logic [15:0] rd(input int a);
    return mem.exists(a) ? mem[a] : 16'hFFFF; // Erased cells read as ones.
  endfunction : rd

  task automatic start(input int k, input logic [19:0] a, input logic [15:0] d);
    kind = k;
    op_a = a;
    b7 = d[7];
    op_d = word ? d : (d[15] ? {d[7:0], 8'hFF} : {8'hFF, d[7:0]});
    // The high-voltage reset level lifts the lockout for the whole operation.
    remain = (k == 0) ? PROG_NS :
             (a[19:15] == LOCK_BLK && k == 1 && !HV_OVERRIDE) ? LOCK_NS : ERASE_NS;
    busy = 1'b1;
    ->go;
  endtask : start

  task automatic complete();
    int q[$];
    if (kind == 0) mem[op_a] = rd(op_a) & op_d; // Program only clears bits.
    foreach (mem[k])
      if (kind != 0 && (kind == 2 || k[19:15] == op_a[19:15])
          && (k[19:15] != LOCK_BLK || HV_OVERRIDE))
        q.push_back(k); // Locked blocks survive both erases.
    foreach (q[i]) mem.delete(q[i]);
  endtask : complete

  // Command decoder; a mismatched cycle falls back to read mode.
  task automatic wr(input logic [19:0] a, input logic [15:0] d);
    logic [7:0] c;
    c = d[7:0]; // Upper data lines are ignored for commands.
    if (busy && !susp) begin
      if (kind != 0 && c == CODE_SUSPEND) susp = 1'b1; // Programs ignore commands.
    end else if (bypass) start(0, a, d); // Every pulse programs, erase codes too.
    else if (susp && c == CODE_RESUME) susp = 1'b0;
    else case (step)
      3'h0, 3'h3: step = (a == UNLOCK_ADDR_1 && c == CODE_UNLOCK_1) ? step + 3'h1 : 3'h0;
      3'h1, 3'h4: step = (a == UNLOCK_ADDR_2 && c == CODE_UNLOCK_2) ? step + 3'h1 : 3'h0;
      3'h2: step = (a != UNLOCK_ADDR_1) ? 3'h0 : (c == CODE_PROGRAM) ? 3'h6 :
                   (c == CODE_ERASE) ? 3'h3 : 3'h0;
      3'h5: begin
        step = 3'h0;
        if (c == CODE_SECTOR) start(1, a, d);
        else if (a == UNLOCK_ADDR_1 && c == CODE_CHIP) start(2, a, d);
        else if (a == UNLOCK_ADDR_1 && c == CODE_BYPASS) bypass = 1'b1;
      end
      default: begin
        step = 3'h0;
        start(0, a, d);
      end
    endcase
  endtask : wr

  // Address at the later falling strobe, data at the first rising one.
  always @(negedge we_n or negedge ce_n)
    if (!we_n && !ce_n && oe_n) la = addr;
  always @(posedge we_n or posedge ce_n)
    if ((we_n ^ ce_n) && oe_n && reset_n) wr(la, dq_in);

  // Self-timed operation; suspend freezes it and a reset aborts it.
  always begin
    @go;
    while (remain > 0 && reset_n) begin
      #10;
      if (!susp) remain -= 10;
    end
    if (reset_n) complete();
    busy = 1'b0;
    susp = 1'b0;
  end

  // Reset low drops any partial sequence and the single-pulse mode.
  always @(negedge reset_n) begin
    step = 3'h0;
    bypass = 1'b0;
  end

  always @(negedge oe_n) if (busy && !ce_n) tog = ~tog;

  // Read path; status replaces data only in the plane that is busy.
  initial dq_out = 16'h0000;
  always @(addr, ce_n, oe_n, we_n, reset_n, word, dq_in[15], busy, tog, susp) begin
    w = rd(addr);
    if (!word) w = dq_in[15] ? {8'h00, w[15:8]} : {8'h00, w[7:0]};
    if (busy && !susp && (addr[19:18] == 2'b00) == (op_a[19:18] == 2'b00)) begin
      w[7] = (kind == 0) ? ~b7 : 1'b0;
      w[6] = tog;
    end
    dq_en = (!ce_n && !oe_n && we_n && reset_n) ? (word ? 16'hFFFF : 16'h00FF) : 16'h0000;
    if (dq_en[0]) dq_out = w;
  end
  assign ready = ~busy;
endmodule : dpfc_flash_model

//--- verif/dpfc_host_tb.sv
// Self-checking bench for the flash host controller against the device model.
`timescale 1ns/1ns
module dpfc_host_tb
  import dpfc_pkg::*;
;
  localparam int LIMIT = 60000;
  logic              clk, rst, cmd_valid, cmd_ready, word_mode, rsp_valid, rsp_error;
  logic              bypass_active, erase_suspended, flash_ce_n, flash_oe_n, flash_we_n;
  logic              flash_reset_n, flash_byte, flash_ready, saw_busy, got_err;
  dpfc_op_t          cmd_op;
  logic [ADDR_W-1:0] cmd_addr, flash_addr;
  logic [DATA_W-1:0] cmd_data, rsp_data, flash_dq_out, flash_dq_oe, flash_dq_in;
  logic [DATA_W-1:0] dev_dq, dev_en, got, last_oe, dw;
  int                error_cnt = 0, n_tests = 0, n_we = 0, n_bad = 0, cyc = 0;

  dpfc_host dpfc_host_inst (.clk, .rst, .cmd_valid, .cmd_ready, .cmd_op, .cmd_addr, .cmd_data,
    .word_mode, .rsp_valid, .rsp_data, .rsp_error, .bypass_active, .erase_suspended,
    .flash_addr, .flash_dq_out, .flash_dq_oe, .flash_dq_in, .flash_ce_n, .flash_oe_n,
    .flash_we_n, .flash_reset_n, .flash_byte, .flash_ready);
  dpfc_flash_model dpfc_flash_model_inst (.addr(flash_addr), .dq_in(flash_dq_in),
    .ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n), .reset_n(flash_reset_n),
    .word(flash_byte), .dq_out(dev_dq), .dq_en(dev_en), .ready(flash_ready));

  // Undriven lines show the inverse of their last value so stale data cannot pass.
  assign flash_dq_in = (flash_dq_oe & flash_dq_out) | (~flash_dq_oe & (dev_en ~^ dev_dq));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Pin watcher: counts write pulses and checks strobe levels at each pulse.
  always @(negedge flash_we_n) begin
    n_we++;
    last_oe = flash_dq_oe;
    if (flash_oe_n !== 1'b1 || flash_ce_n !== 1'b0) n_bad++;
  end
  always @(negedge flash_oe_n) if (flash_we_n !== 1'b1 || flash_ce_n !== 1'b0) n_bad++;

  // Busy pin sampling and the hang guard.
  always @(posedge clk) begin
    if (flash_ready === 1'b0) saw_busy = 1'b1;
    cyc++;
    if (cyc == LIMIT) begin
      error_cnt++;
      test_done();
    end
  end

  task automatic test_done();
    $display("tests=%0d errors=%0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // One command: held until taken, then wait for the answer pulse.
  task automatic run(input dpfc_op_t op, input logic [19:0] a, input logic [15:0] d);
    int k, w0;
    w0 = n_we;
    @(negedge clk);
    cmd_op = op;
    cmd_addr = a;
    cmd_data = d;
    cmd_valid = 1'b1;
    @(posedge clk);
    for (k = 0; k < 100 && cmd_ready !== 1'b1; k++) @(posedge clk);
    for (k = 0; k < 20000 && rsp_valid !== 1'b1; k++) begin
      @(negedge clk);
      cmd_valid = 1'b0;
    end
    got = rsp_data;
    got_err = rsp_error;
    dw = 16'(n_we - w0);
    chk({15'h0000, rsp_valid}, 16'h0001);
  endtask : run

  task automatic rd_chk(input logic [19:0] a, input logic [15:0] e);
    run(DPFC_OP_READ, a, 16'h0000);
    chk(got, e);
  endtask : rd_chk

  task automatic t_reset();
    chk({13'h0000, flash_ce_n, flash_oe_n, flash_we_n}, 16'h0007);
    chk({15'h0000, flash_reset_n}, 16'h0001);
    rd_chk(20'h4_0000, 16'hFFFF);
  endtask : t_reset

  task automatic t_program();
    saw_busy = 1'b0;
    run(DPFC_OP_PROGRAM, 20'h4_0010, 16'h1234);
    chk(dw, 16'h0004);
    chk({got_err, 14'h0000, saw_busy}, 16'h0001);
    rd_chk(20'h4_0010, 16'h1234);
    run(DPFC_OP_PROGRAM, 20'h4_0010, 16'hFF0F);
    rd_chk(20'h4_0010, 16'h1204);
  endtask : t_program

  // Suspend and resume are single writes; the flag follows them.
  task automatic t_suspend();
    run(DPFC_OP_SUSPEND, 20'h4_0000, 16'h0000);
    chk({dw[14:0], erase_suspended}, 16'h0003);
    run(DPFC_OP_RESUME, 20'h4_0000, 16'h0000);
    chk({dw[14:0], erase_suspended}, 16'h0002);
  endtask : t_suspend

  task automatic t_erase();
    run(DPFC_OP_PROGRAM, 20'hF_8000, 16'h0000);
    run(DPFC_OP_SECTOR_ERASE, 20'h4_0000, 16'h0000);
    chk(dw, 16'h0006);
    rd_chk(20'h4_0010, 16'hFFFF);
    run(DPFC_OP_SECTOR_ERASE, 20'hF_8000, 16'h0000);
    rd_chk(20'hF_8000, 16'h0000);
    run(DPFC_OP_PROGRAM, 20'h4_0010, 16'h0000);
    run(DPFC_OP_CHIP_ERASE, 20'h0_0000, 16'h0000);
    chk(dw, 16'h0006);
    rd_chk(20'h4_0010, 16'hFFFF);
    rd_chk(20'hF_8000, 16'h0000);
  endtask : t_erase

  task automatic t_byte();
    @(negedge clk);
    word_mode = 1'b0;
    @(negedge clk);
    chk({15'h0000, flash_byte}, 16'h0000);
    run(DPFC_OP_PROGRAM, 20'h4_0020, 16'h805A);
    chk(last_oe, 16'h80FF);
    run(DPFC_OP_READ, 20'h4_0020, 16'h8000);
    chk({8'h00, got[7:0]}, 16'h005A);
    run(DPFC_OP_READ, 20'h4_0020, 16'h0000);
    chk({8'h00, got[7:0]}, 16'h00FF);
    @(negedge clk);
    word_mode = 1'b1;
    rd_chk(20'h4_0020, 16'h5AFF);
  endtask : t_byte

  task automatic t_bypass();
    dpfc_op_t ops [5] = '{DPFC_OP_CHIP_ERASE, DPFC_OP_SECTOR_ERASE, DPFC_OP_SUSPEND,
                          DPFC_OP_RESUME, DPFC_OP_BYPASS};
    run(DPFC_OP_BYPASS, 20'h0_0000, 16'h0000);
    chk({dw[14:0], bypass_active}, 16'h000D);
    run(DPFC_OP_PROGRAM, 20'h4_0030, 16'h00F0);
    chk(dw, 16'h0001);
    rd_chk(20'h4_0030, 16'h00F0);
    foreach (ops[i]) begin
      run(ops[i], 20'h4_0000, 16'h0000);
      chk({got_err, dw[14:0]}, 16'h8000);
    end
    rd_chk(20'h4_0030, 16'h00F0);
    run(DPFC_OP_RESET, 20'h0_0000, 16'h0000);
    chk({got_err, 14'h0000, bypass_active}, 16'h0000);
    run(DPFC_OP_PROGRAM, 20'h4_0030, 16'h0030);
    chk(dw, 16'h0004);
    rd_chk(20'h4_0030, 16'h0030);
  endtask : t_bypass

  // Reset for sixteen cycles, then each scenario in turn.
  initial begin
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = DPFC_OP_READ;
    cmd_addr = 20'h0_0000;
    cmd_data = 16'h0000;
    word_mode = 1'b1;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_reset();
    t_program();
    t_suspend();
    t_erase();
    t_byte();
    t_bypass();
    chk(16'(n_bad), 16'h0000);
    test_done();
  end
endmodule : dpfc_host_tb
